/* File: design/pit_timer.sv */
/*
  Periodic tick timer with an AHB-Lite register slave.
  Assumes a single AHB-Lite master, 32-bit word accesses, and a debug halt
  level arriving asynchronously from the debug logic.
*/
// How it works
// - a 4-bit period code at bits 6:3 selects 2^(code+1) ticks, 0 gives no event, 15 is reserved.
// - the timer runs only while the enable bit 0 of timer_control is one.
// - status bit 0 is high while a timer_control write crosses into the tick domain.
// - bit 0 of periodic_irq_enable enables the interrupt request, zero disables it.
// - the periodic flag is set each time the selected interval elapses.
// - writing one to the flag clears it, writing zero leaves it.
// - with the debug-run bit zero the timer halts during a debug break and ignores events.
// - with the debug-run bit one the timer keeps counting during a debug break.
module pit_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cpu_debug_halt,
  output logic tick_event,
  output logic irq
);

  typedef struct packed {
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr_idx;
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_act;
    logic busy;
    logic [pit_pkg::SYNC_CNT_W-1:0] sync_cnt;
    logic irqen;
    logic flag;
    logic run_in_debug_break;
    logic [pit_pkg::TICK_DIV_W-1:0] div_cnt;
    logic tick;
    logic dbg_s1;
    logic dbg_s2;
    logic event_q;
    logic [pit_pkg::TICK_DIV_W:0] busy_age;
  } pit_state_t;

  pit_state_t s_q;
  pit_state_t s_d;

  pit_tick_if tif ();

  // word index from a byte address; anything not word-aligned maps nowhere
  function automatic logic [7:0] word_index(input logic [31:0] a);
    if (a[1:0] != 2'b00 || a[31:10] != '0)
      return 8'hff;
    return a[9:2];
  endfunction

  function automatic logic is_ctrl(input logic [7:0] idx);
    return idx == pit_pkg::IDX_TIMER_CONTROL;
  endfunction

  logic addr_phase;
  logic halted;
  logic sync_done;
  logic flag_clear;
  logic ctrl_write;

  // only NONSEQ/SEQ with the bus ready open a transfer
  assign addr_phase = hsel && htrans[1] && hready;
  // debug break halts unless run_in_debug_break is set
  assign halted = s_q.dbg_s2 && !s_q.run_in_debug_break;
  assign sync_done = s_q.busy && s_q.tick
    && (s_q.sync_cnt == pit_pkg::SYNC_CNT_W'(pit_pkg::SYNC_TICKS - 1));
  assign ctrl_write = s_q.wr_pend && is_ctrl(s_q.addr_idx);
  assign flag_clear = s_q.wr_pend && (s_q.addr_idx == pit_pkg::IDX_PERIODIC_IRQ_FLAG)
    && hwdata[pit_pkg::PERIODIC_FLAG_BIT];

  always_comb
  begin
    s_d = s_q;

    // bus address phase
    s_d.wr_pend = addr_phase && hwrite;
    s_d.rd_pend = addr_phase && !hwrite;
    if (addr_phase)
      s_d.addr_idx = word_index(haddr);

    // tick divider, free running so the sync handshake always completes
    s_d.tick = 1'b0;
    if (s_q.div_cnt == pit_pkg::TICK_DIV_W'(pit_pkg::TICK_DIV - 1))
    begin
      s_d.div_cnt = '0;
      s_d.tick = 1'b1;
    end
    else
      s_d.div_cnt = s_q.div_cnt + 1'b1;

    // debug halt synchroniser
    s_d.dbg_s1 = cpu_debug_halt;
    s_d.dbg_s2 = s_q.dbg_s1;

    // control crossing: new value takes effect after SYNC_TICKS tick edges
    if (sync_done)
    begin
      s_d.ctrl_act = s_q.ctrl_q;
      s_d.busy = 1'b0;
      s_d.sync_cnt = '0;
    end
    else if (s_q.busy && s_q.tick)
      s_d.sync_cnt = s_q.sync_cnt + 1'b1;

    // bus data phase writes; a timer_control write while busy restarts the crossing
    if (s_q.wr_pend)
    begin
      unique case (s_q.addr_idx)
        pit_pkg::IDX_TIMER_CONTROL:
        begin
          s_d.ctrl_q = hwdata[7:0] & 8'h79;
          s_d.busy = 1'b1;
          s_d.sync_cnt = '0;
        end
        pit_pkg::IDX_PERIODIC_IRQ_ENABLE:
          s_d.irqen = hwdata[pit_pkg::TICK_IRQ_ENABLE_BIT];
        pit_pkg::IDX_TIMER_DEBUG_CONTROL:
          s_d.run_in_debug_break = hwdata[pit_pkg::RUN_IN_DEBUG_BREAK_BIT];
        default:
        begin
        end
      endcase
    end

    // periodic flag: a new event wins over a same-cycle clear
    s_d.event_q = tif.event_pulse;
    if (tif.event_pulse)
      s_d.flag = 1'b1;
    else if (flag_clear)
      s_d.flag = 1'b0;

    // checking aid: cycles the busy bit has stood since the last control write
    if (!s_q.busy || ctrl_write)
      s_d.busy_age = '0;
    else
      s_d.busy_age = s_q.busy_age + 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q <= '0;
      s_q.ctrl_q <= pit_pkg::TIMER_CONTROL_RESET;
      s_q.ctrl_act <= pit_pkg::TIMER_CONTROL_RESET;
      s_q.busy <= pit_pkg::TIMER_SYNC_STATUS_RESET[pit_pkg::CONTROL_SYNC_BUSY_BIT];
      s_q.irqen <= pit_pkg::PERIODIC_IRQ_ENABLE_RESET[pit_pkg::TICK_IRQ_ENABLE_BIT];
      s_q.flag <= pit_pkg::PERIODIC_IRQ_FLAG_RESET[pit_pkg::PERIODIC_FLAG_BIT];
      s_q.run_in_debug_break <= pit_pkg::TIMER_DEBUG_CONTROL_RESET[pit_pkg::RUN_IN_DEBUG_BREAK_BIT];
    end
    else
      s_q <= s_d;
  end

  // counter side: cleared while disabled or when a new value lands
  assign tif.tick_en = s_q.tick;
  assign tif.run = s_q.ctrl_act[pit_pkg::TICK_TIMER_ENABLE_BIT] && !halted;
  assign tif.clear = !s_q.ctrl_act[pit_pkg::TICK_TIMER_ENABLE_BIT] || sync_done;
  assign tif.period = s_q.ctrl_act[pit_pkg::PERIOD_MSB:pit_pkg::PERIOD_LSB];

  pit_period_counter u_counter (
    .hclk(hclk),
    .hresetn(hresetn),
    .tif(tif)
  );

  // read mux over registered state; unmapped words read zero
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    unique case (s_q.addr_idx)
      pit_pkg::IDX_TIMER_CONTROL:
        rd_byte = s_q.ctrl_q;
      pit_pkg::IDX_TIMER_SYNC_STATUS:
        rd_byte = {7'h00, s_q.busy};
      pit_pkg::IDX_PERIODIC_IRQ_ENABLE:
        rd_byte = {7'h00, s_q.irqen};
      pit_pkg::IDX_PERIODIC_IRQ_FLAG:
        rd_byte = {7'h00, s_q.flag};
      pit_pkg::IDX_TIMER_DEBUG_CONTROL:
        rd_byte = {7'h00, s_q.run_in_debug_break};
      default:
        rd_byte = 8'h00;
    endcase
  end

  // zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rd_pend ? {24'h000000, rd_byte} : 32'h00000000;
  assign tick_event = s_q.event_q;
  assign irq = s_q.flag && s_q.irqen;

  // helper: status read mirrors busy
  logic rd_byte_busy_ok;
  assign rd_byte_busy_ok = (s_q.addr_idx != pit_pkg::IDX_TIMER_SYNC_STATUS)
    || (rd_byte[pit_pkg::CONTROL_SYNC_BUSY_BIT] == s_q.busy);

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  flag_on_event_a: assert property (tif.event_pulse |=> s_q.flag)
    else $error("flag not set by periodic event");
  flag_clear_one_a: assert property (flag_clear && !tif.event_pulse |=> !s_q.flag)
    else $error("flag not cleared by write of one");
  flag_keep_zero_a: assert property (s_q.wr_pend
    && s_q.addr_idx == pit_pkg::IDX_PERIODIC_IRQ_FLAG
    && !hwdata[pit_pkg::PERIODIC_FLAG_BIT] && s_q.flag |=> s_q.flag)
    else $error("flag lost on write of zero");
  busy_on_write_a: assert property (ctrl_write |=> s_q.busy ##0 rd_byte_busy_ok)
    else $error("busy not raised by control write");
  busy_drop_apply_a: assert property ($fell(s_q.busy) |-> s_q.ctrl_act == s_q.ctrl_q)
    else $error("busy fell before control applied");
  active_held_a: assert property (s_q.busy && !sync_done |=> $stable(s_q.ctrl_act))
    else $error("control applied while still crossing");
  disabled_quiet_a: assert property (!s_q.ctrl_act[pit_pkg::TICK_TIMER_ENABLE_BIT]
    |=> !tif.event_pulse)
    else $error("event while timer disabled");
  irq_masked_a: assert property (!s_q.irqen |-> !irq)
    else $error("interrupt request while disabled");
  irq_follow_a: assert property ($rose(s_q.flag) && s_q.irqen |-> irq)
    else $error("interrupt request missing for set flag");
  break_halt_a: assert property (s_q.dbg_s2 && !s_q.run_in_debug_break |-> !tif.run)
    else $error("timer running during debug break");
  break_run_a: assert property (s_q.dbg_s2 && s_q.run_in_debug_break
    && s_q.ctrl_act[pit_pkg::TICK_TIMER_ENABLE_BIT] |-> tif.run)
    else $error("timer stopped during debug break with run set");

  // divider: one-cycle tick, fixed period, never past its end
  tick_lone_a: assert property (s_q.tick |=> !s_q.tick)
    else $error("tick enable longer than one cycle");

  div_wrap_a: assert property (
    s_q.div_cnt == pit_pkg::TICK_DIV_W'(pit_pkg::TICK_DIV - 1)
    |=> s_q.tick && s_q.div_cnt == '0)
    else $error("divider did not wrap into a tick");

  div_bound_a: assert property (
    s_q.div_cnt <= pit_pkg::TICK_DIV_W'(pit_pkg::TICK_DIV - 1))
    else $error("divider beyond its period");

  // crossing: counter idle when not busy, bounded length, lands the held value
  sync_idle_a: assert property (!s_q.busy |-> s_q.sync_cnt == '0)
    else $error("crossing count moved while idle");

  sync_bound_a: assert property (
    s_q.sync_cnt <= pit_pkg::SYNC_CNT_W'(pit_pkg::SYNC_TICKS - 1))
    else $error("crossing count beyond its end");

  busy_bounded_a: assert property (int'(s_q.busy_age) <= 2 * pit_pkg::TICK_DIV)
    else $error("busy stood longer than two ticks");

  busy_land_a: assert property (sync_done && !ctrl_write
    |=> !s_q.busy && s_q.ctrl_act == $past(s_q.ctrl_q))
    else $error("crossing end did not land the control value");

  // register writes land the data-phase value
  ctrl_store_a: assert property (ctrl_write
    |=> s_q.ctrl_q == ($past(hwdata[7:0]) & 8'h79))
    else $error("control write not stored");

  irqen_store_a: assert property (s_q.wr_pend
    && s_q.addr_idx == pit_pkg::IDX_PERIODIC_IRQ_ENABLE
    |=> s_q.irqen == $past(hwdata[pit_pkg::TICK_IRQ_ENABLE_BIT]))
    else $error("interrupt enable write not stored");

  run_in_debug_break_store_a: assert property (s_q.wr_pend
    && s_q.addr_idx == pit_pkg::IDX_TIMER_DEBUG_CONTROL
    |=> s_q.run_in_debug_break == $past(hwdata[pit_pkg::RUN_IN_DEBUG_BREAK_BIT]))
    else $error("debug run write not stored");

  // bus phases
  read_open_a: assert property (addr_phase && !hwrite |=> s_q.rd_pend && !s_q.wr_pend)
    else $error("read address phase not taken");

  write_open_a: assert property (addr_phase && hwrite
    |=> s_q.wr_pend && s_q.addr_idx == $past(word_index(haddr)))
    else $error("write address phase not taken");

  rdata_quiet_a: assert property (!s_q.rd_pend |-> hrdata == 32'h00000000)
    else $error("read data outside a read data phase");

  // debug halt passes both synchroniser stages
  dbg_sync_a: assert property (s_q.dbg_s1 |=> s_q.dbg_s2)
    else $error("debug halt skipped a synchroniser stage");

  // events only from a running, valid, counting tick
  event_run_a: assert property (tif.event_pulse
    |-> $past(tif.run) && $past(tif.tick_en) && !$past(tif.clear))
    else $error("event without a running tick");

  code_quiet_a: assert property (tif.period == pit_pkg::PERIOD_OFF
    || tif.period == pit_pkg::PERIOD_RESERVED |=> !tif.event_pulse)
    else $error("event from off or reserved period code");

  disabled_clear_a: assert property (!s_q.ctrl_act[pit_pkg::TICK_TIMER_ENABLE_BIT]
    |-> tif.clear)
    else $error("counter not cleared while disabled");

  tick_out_a: assert property (tif.event_pulse |=> tick_event)
    else $error("event not shown on tick_event");

  // flag: only an event raises it, only a written one lowers it
  flag_cause_a: assert property ($rose(s_q.flag) |-> $past(tif.event_pulse))
    else $error("flag rose without an event");

  flag_hold_a: assert property (s_q.flag && !flag_clear |=> s_q.flag)
    else $error("flag dropped without a clear");

endmodule

/* File: design/pit_pkg.sv */
/*
  Constants shared by the periodic tick timer: register indices, field
  positions, reset values and timing counts.
  Assumes a 100 MHz bus clock and a 32768 Hz tick clock derived from it.
*/
package pit_pkg;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] IDX_TIMER_CONTROL = 8'h10;
  localparam logic [7:0] IDX_TIMER_SYNC_STATUS = 8'h11;
  localparam logic [7:0] IDX_PERIODIC_IRQ_ENABLE = 8'h12;
  localparam logic [7:0] IDX_PERIODIC_IRQ_FLAG = 8'h13;
  localparam logic [7:0] IDX_TIMER_DEBUG_CONTROL = 8'h15;

  // field positions
  localparam int TICK_TIMER_ENABLE_BIT = 0;
  localparam int PERIOD_LSB = 3;
  localparam int PERIOD_MSB = 6;
  localparam int CONTROL_SYNC_BUSY_BIT = 0;
  localparam int TICK_IRQ_ENABLE_BIT = 0;
  localparam int PERIODIC_FLAG_BIT = 0;
  localparam int RUN_IN_DEBUG_BREAK_BIT = 0;

  // reset values
  localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] TIMER_SYNC_STATUS_RESET = 8'h00;
  localparam logic [7:0] PERIODIC_IRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] PERIODIC_IRQ_FLAG_RESET = 8'h00;
  localparam logic [7:0] TIMER_DEBUG_CONTROL_RESET = 8'h00;

  // period selector codes
  localparam logic [3:0] PERIOD_OFF = 4'h0;
  localparam logic [3:0] PERIOD_RESERVED = 4'hf;
  localparam int PERIOD_CNT_W = 15;

  // timing: tick clock is an enable pulse divided down from the bus clock
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_HZ = 32_768;
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int TICK_DIV_W = 12;
  // control crosses into the tick domain after this many tick edges
  localparam int SYNC_TICKS = 2;
  localparam int SYNC_CNT_W = 2;

endpackage

/* File: design/pit_tick_if.sv */
/*
  Bundle between the register side and the period counter.
  Assumes both ends run on the same bus clock; tick_en is a one-cycle enable.
*/
interface pit_tick_if;
  logic tick_en;
  logic run;
  logic clear;
  logic [3:0] period;
  logic event_pulse;

  modport ctl (
    output tick_en,
    output run,
    output clear,
    output period,
    input event_pulse
  );

  modport cnt (
    input tick_en,
    input run,
    input clear,
    input period,
    output event_pulse
  );
endinterface

/* File: design/pit_period_counter.sv */
/*
  Power-of-two period counter of the tick timer.
  Assumes tick_en pulses once per tick clock cycle and clear comes from the
  register side on disable or on a new control value.
*/
module pit_period_counter (
  input wire logic hclk,
  input wire logic hresetn,
  pit_tick_if.cnt tif
);

  typedef struct packed {
    logic [pit_pkg::PERIOD_CNT_W-1:0] cnt;
    logic event_pulse;
  } pit_cnt_state_t;

  pit_cnt_state_t s_q;
  pit_cnt_state_t s_d;

  // low code+1 bits set: interval of 2^(code+1) ticks
  function automatic logic [pit_pkg::PERIOD_CNT_W-1:0] period_mask(input logic [3:0] code);
    logic [pit_pkg::PERIOD_CNT_W-1:0] m;
    m = '0;
    for (int i = 0; i < pit_pkg::PERIOD_CNT_W; i++)
    begin
      if (i <= int'(code))
        m[i] = 1'b1;
    end
    return m;
  endfunction

  function automatic logic code_valid(input logic [3:0] code);
    return (code != pit_pkg::PERIOD_OFF) && (code != pit_pkg::PERIOD_RESERVED);
  endfunction

  logic [pit_pkg::PERIOD_CNT_W-1:0] mask;
  assign mask = period_mask(tif.period);

  always_comb
  begin
    s_d = s_q;
    s_d.event_pulse = 1'b0;
    if (tif.clear)
      s_d.cnt = '0;
    else if (tif.tick_en && tif.run)
    begin
      s_d.cnt = s_q.cnt + 1'b1;
      if (code_valid(tif.period) && ((s_q.cnt & mask) == mask))
        s_d.event_pulse = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tif.event_pulse = s_q.event_pulse;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  event_code_ok_a: assert property (s_q.event_pulse |-> code_valid($past(tif.period))
    && (($past(s_q.cnt) & $past(mask)) == $past(mask)))
    else $error("tick event with bad period code or count");
  halt_holds_a: assert property (!tif.run && !tif.clear |=> s_q.cnt == $past(s_q.cnt))
    else $error("counter moved while halted");

endmodule

/* File: tb/tb.sv */
/*
  Self-checking bench for the periodic tick timer, driven over AHB-Lite.
  Assumes hreadyout feeds hready and a fixed tick divider in the design.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] R_CTL = pit_pkg::IDX_TIMER_CONTROL;
  localparam logic [7:0] R_STA = pit_pkg::IDX_TIMER_SYNC_STATUS;
  localparam logic [7:0] R_IEN = pit_pkg::IDX_PERIODIC_IRQ_ENABLE;
  localparam logic [7:0] R_FLG = pit_pkg::IDX_PERIODIC_IRQ_FLAG;
  localparam logic [7:0] R_DBG = pit_pkg::IDX_TIMER_DEBUG_CONTROL;
  localparam int PER1 = 4 * pit_pkg::TICK_DIV;
  localparam int WIN = PER1 + 96;
  logic hclk, hresetn, hsel, hwrite, hready, cpu_debug_halt;
  logic hreadyout, hresp, tick_event, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int n_fail, cmp_count, cyc, ev_cnt, t_ev, t0, k;

  pit_timer DUT (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .cpu_debug_halt(cpu_debug_halt),
    .tick_event(tick_event),
    .irq(irq)
  );
  assign hready = hreadyout;

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic end_of_test;
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // run is about 92k cycles; ceiling leaves a little slack
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (tick_event === 1'b1)
      ev_cnt <= ev_cnt + 1;
    if (cyc >= 100000)
    begin
      n_fail = n_fail + 1;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // single transfer; every change lands just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1 && ++n < 20);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1 && ++n < 40);
    rd = hrdata;
    chk("bus answer", 32'h1, {31'h0, hready});
    chk("bus response", 32'h0, {31'h0, hresp});
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(nm, exp, rd);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do bus(1'b0, R_STA, 32'h0); while (rd[0] !== 1'b0 && ++n < 4000);
    chk("busy cleared", 32'h0, rd);
  endtask

  task automatic wait_ev;
    int n;
    n = 0;
    do @(posedge hclk); while (tick_event !== 1'b1 && ++n < WIN);
    t_ev = cyc;
    chk("event seen", 32'h1, {31'h0, tick_event});
  endtask

  // counts events over a window longer than the shortest period
  task automatic quiet(input string nm, input int exp);
    int e0;
    e0 = ev_cnt;
    repeat (WIN) @(posedge hclk);
    chk(nm, 32'(exp), 32'(ev_cnt - e0));
  endtask

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cpu_debug_halt = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("control reset", R_CTL, 32'h0);
    rd_chk("status reset", R_STA, 32'h0);
    rd_chk("irq enable reset", R_IEN, 32'h0);
    rd_chk("flag reset", R_FLG, 32'h0);
    rd_chk("debug reset", R_DBG, 32'h0);
    bus(1'b1, R_STA, 32'hff);
    rd_chk("status read only", R_STA, 32'h0);
    bus(1'b1, 8'h14, 32'hff);
    rd_chk("unmapped", 8'h14, 32'h0);
    bus(1'b1, R_IEN, 32'hff);
    rd_chk("irq enable", R_IEN, 32'h1);
    bus(1'b1, R_CTL, 32'h09);
    rd_chk("busy set", R_STA, 32'h1);
    wait_idle();
    rd_chk("control", R_CTL, 32'h09);
    wait_ev();
    chk("irq raised", 32'h1, {31'h0, irq});
    rd_chk("flag set", R_FLG, 32'h1);
    t0 = t_ev;
    wait_ev();
    chk("interval", 32'(PER1), 32'(t_ev - t0));
    bus(1'b1, R_FLG, 32'h0);
    rd_chk("flag kept", R_FLG, 32'h1);
    bus(1'b1, R_FLG, 32'h1);
    @(posedge hclk);
    chk("irq dropped", 32'h0, {31'h0, irq});
    rd_chk("flag cleared", R_FLG, 32'h0);
    bus(1'b1, R_IEN, 32'h0);
    cpu_debug_halt <= 1'b1;
    quiet("halted events", 0);
    bus(1'b1, R_DBG, 32'hff);
    rd_chk("debug run", R_DBG, 32'h1);
    quiet("break events", 1);
    rd_chk("flag in break", R_FLG, 32'h1);
    chk("irq masked", 32'h0, {31'h0, irq});
    cpu_debug_halt <= 1'b0;
    // code 0xf with enable set: fields outside 6:3 and 0 read zero
    bus(1'b1, R_CTL, 32'hff);
    wait_idle();
    rd_chk("control fields", R_CTL, 32'h79);
    quiet("reserved code", 0);
    bus(1'b1, R_CTL, 32'h08);
    wait_idle();
    quiet("disabled", 0);
    end_of_test();
  end
endmodule
